// File: rtl/meel_map.svh
`ifndef MEEL_MAP_SVH
`define MEEL_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define MEEL_ADDR_UPPER 3'h0
`define MEEL_ADDR_LOWER 3'h1
`define MEEL_ADDR_DIAG 3'h2
`define MEEL_ADDR_STATUS 3'h3
// ****************************************
// upper log half fields
// ****************************************
`define MEEL_UP_SCRUB 15
`define MEEL_UP_SYN_HI 14
`define MEEL_UP_SYN_LO 8
`define MEEL_UP_FBE 7
`define MEEL_UP_OVF 6
`define MEEL_UP_UNC 5
`define MEEL_UP_COR 4
`define MEEL_UP_LOC_HI 3
`define MEEL_LOC_SPLIT 16
// ****************************************
// diagnostic register fields
// ****************************************
`define MEEL_DG_DIS_REPORT 0
`define MEEL_DG_DIS_ECC 1
`define MEEL_DG_DIS_SCRUB 2
`define MEEL_DIAG_RESET 3'h0
// ****************************************
// status register fields
// ****************************************
`define MEEL_ST_CNT_HI 15
`define MEEL_ST_CNT_LO 14
`define MEEL_ST_PEND 13
`define MEEL_ST_KIND_HI 10
`define MEEL_ST_KIND_LO 8
`define MEEL_ST_IDX_HI 4
// ****************************************
// codes and limits
// ****************************************
`define MEEL_SYN_FBE 7'h7F
`define MEEL_TSEL_CHECKER 2'h0
`define MEEL_TSEL_MASTER 2'h1
`define MEEL_CNT_MAX 2'h3
`define MEEL_CNT_ONE 2'h1
`define MEEL_LOG_RESET 1'h0
`endif

// File: rtl/meel_pkg.sv
package meel_pkg;
  // ****************************************
  // decoded failing bit
  // ****************************************
  typedef enum logic [2:0] {
    MEEL_BIT_NONE,
    MEEL_BIT_DATA,
    MEEL_BIT_ADDR,
    MEEL_BIT_ECC,
    MEEL_BIT_FBE
  } meel_bit_e;
  typedef struct packed {
    meel_bit_e kind;
    logic [4:0] index;
  } meel_fail_s;
  // ****************************************
  // detected array error
  // ****************************************
  typedef struct packed {
    logic valid;
    logic scrub;
    logic [6:0] syndrome;
    logic [19:0] location;
  } meel_ecc_evt_s;
  // ****************************************
  // outgoing report kinds
  // ****************************************
  typedef enum logic [1:0] {
    MEEL_RPT_TEST,
    MEEL_RPT_CORR,
    MEEL_RPT_UNCORR
  } meel_rpt_e;
endpackage

// File: rtl/meel_syn_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "meel_map.svh"
module meel_syn_decode (
  // syndrome in
  input wire logic [6:0] SYNDROME,
  // decoded bit out
  output meel_pkg::meel_fail_s FAIL
);
  // ****************************************
  // syndrome tables, highest bit first
  // ****************************************
  localparam logic [32*7-1:0] DATA_SYN = {
    7'h1F, 7'h16, 7'h0D, 7'h1C, 7'h3B, 7'h32, 7'h29, 7'h64,
    7'h57, 7'h0E, 7'h45, 7'h7C, 7'h73, 7'h2A, 7'h61, 7'h5B,
    7'h4F, 7'h46, 7'h3D, 7'h34, 7'h6B, 7'h62, 7'h19, 7'h52,
    7'h07, 7'h3E, 7'h75, 7'h2C, 7'h23, 7'h1A, 7'h51, 7'h49};
  localparam logic [20*7-1:0] ADDR_SYN = {
    7'h38, 7'h70, 7'h68, 7'h58, 7'h2F, 7'h26, 7'h5D, 7'h54,
    7'h0B, 7'h4A, 7'h79, 7'h76, 7'h67, 7'h5E, 7'h15, 7'h4C,
    7'h43, 7'h7A, 7'h31, 7'h6D};
  logic [31:0] hit_d;
  logic [19:0] hit_a;
  logic [6:0] hit_e;
  // ****************************************
  // per-bit compare
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_cmp
      assign hit_d[g] = (SYNDROME == DATA_SYN[g*7 +: 7]);
      if (g < 20)
      begin : g_a
        assign hit_a[g] = (SYNDROME == ADDR_SYN[g*7 +: 7]);
      end
      if (g < 7)
      begin : g_e
        assign hit_e[g] = (SYNDROME == (7'h01 << g));
      end
    end
  endgenerate
  // ****************************************
  // encode; unlisted codes stay none
  // ****************************************
  always_comb
  begin
    FAIL.kind = meel_pkg::MEEL_BIT_NONE;
    FAIL.index = 5'h00;
    if (SYNDROME == `MEEL_SYN_FBE)
      FAIL.kind = meel_pkg::MEEL_BIT_FBE;
    for (int i = 0; i < 32; i++)
    begin
      if (hit_d[i])
      begin
        FAIL.kind = meel_pkg::MEEL_BIT_DATA;
        FAIL.index = 5'(i);
      end
      if (i < 20 && hit_a[i % 20])
      begin
        FAIL.kind = meel_pkg::MEEL_BIT_ADDR;
        FAIL.index = 5'(i);
      end
      if (i < 7 && hit_e[i % 7])
      begin
        FAIL.kind = meel_pkg::MEEL_BIT_ECC;
        FAIL.index = 5'(i);
      end
    end
  end
endmodule // meel_syn_decode
`default_nettype wire

// File: rtl/meel_top.sv
// How it works
// - syndrome decodes to one failed data, address or check bit, to forced-bad (7F), or to none
// - ecc error while the log holds an entry sets the overflow flag
// - log counts as empty when correctable and uncorrectable flags are clear
// - only the first error after emptying is kept; later details are dropped
// - software clears overflow, uncorrectable and correctable flags one by one
// - address-line, double-bit and unused codes are logged uncorrectable
// - single-bit array failures are logged correctable
// - location holds the 20-bit array-relative word address
// - syndrome and location change only while the log is empty
// - forced-bad-check and overflow flags may change with the log full
// - ecc reporting is enabled after reset; a diag bit turns it off
// - diag bits disable all ecc reporting, or scrub report and log only
// - log-reset broadcast clears this node's report log
// - test-report data picks checker or master; selected node reports
// - scrub errors are logged and reported only into an empty log
// - every forced-bad-check operation sets its flag
// - odd-weight syndromes in the tables are single-bit, 7F is forced-bad; even ones carry no position
`timescale 1ns/1ps
`default_nettype none
`include "meel_map.svh"
module meel_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // array checker
  input wire meel_pkg::meel_ecc_evt_s ECC_EVT,
  input wire logic FBE_OP,
  // commands and report network
  input wire logic TEST_REPORT,
  input wire logic [1:0] TEST_SEL,
  input wire logic NODE_IS_MASTER,
  input wire logic LOG_RESET_BCAST,
  input wire logic REPORT_SEEN,
  output logic REPORT_REQ,
  output meel_pkg::meel_rpt_e REPORT_KIND
);
  // ****************************************
  // state
  // ****************************************
  logic cor_r;
  logic unc_r;
  logic ovf_r;
  logic fbe_r;
  logic scrub_r;
  logic [6:0] syn_r;
  logic [19:0] loc_r;
  meel_pkg::meel_fail_s fail_r;
  logic [2:0] diag_r;
  logic [1:0] rcnt_r;
  logic test_pend_r;
  logic [15:0] rdata_r;
  logic req_r;
  meel_pkg::meel_rpt_e kind_r;
  // ****************************************
  // decode and classify
  // ****************************************
  meel_pkg::meel_fail_s evt_fail;
  logic log_empty;
  logic evt_take;
  logic evt_corr;
  logic log_new;
  logic ecc_rpt;
  logic test_hit;
  logic wr_up;
  logic wr_diag;
  logic [15:0] up_word;
  logic [15:0] st_word;

  meel_syn_decode u_dec (
    .SYNDROME (ECC_EVT.syndrome),
    .FAIL (evt_fail)
  );

  assign log_empty = !cor_r && !unc_r;
  // scrub disable suppresses logging as well as reporting
  assign evt_take = ECC_EVT.valid &&
                    !(ECC_EVT.scrub && diag_r[`MEEL_DG_DIS_SCRUB]);
  // only odd weight and a data or check bit hit is fixable in place
  assign evt_corr = (^ECC_EVT.syndrome) &&
                    (evt_fail.kind == meel_pkg::MEEL_BIT_DATA ||
                     evt_fail.kind == meel_pkg::MEEL_BIT_ECC);
  assign log_new = evt_take && log_empty;
  assign wr_up = WR && (ADDR == `MEEL_ADDR_UPPER);
  assign wr_diag = WR && (ADDR == `MEEL_ADDR_DIAG);
  // ****************************************
  // severity flags
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cor_r <= `MEEL_LOG_RESET;
      unc_r <= `MEEL_LOG_RESET;
    end
    else
    begin
      // set wins; a clear in the same cycle is ignored
      if (log_new)
      begin
        cor_r <= evt_corr;
        unc_r <= !evt_corr;
      end
      else if (wr_up)
      begin
        if (WDATA[`MEEL_UP_COR])
          cor_r <= 1'b0;
        if (WDATA[`MEEL_UP_UNC])
          unc_r <= 1'b0;
      end
    end
  end
  // ****************************************
  // overflow flag
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
      ovf_r <= `MEEL_LOG_RESET;
    else if (evt_take && !log_empty)
      ovf_r <= 1'b1;
    else if (wr_up && WDATA[`MEEL_UP_OVF])
      ovf_r <= 1'b0;
  end
  // ****************************************
  // forced-bad-check flag
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
      fbe_r <= `MEEL_LOG_RESET;
    else if (FBE_OP)
      fbe_r <= 1'b1;
    else if (wr_up && WDATA[`MEEL_UP_FBE])
      fbe_r <= 1'b0;
  end
  // ****************************************
  // captured details
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      scrub_r <= `MEEL_LOG_RESET;
      syn_r <= 7'h00;
      loc_r <= 20'h00000;
      fail_r <= '0;
    end
    else if (log_new)
    begin
      // all fields with the severity flag, so a read never tears
      scrub_r <= ECC_EVT.scrub;
      syn_r <= ECC_EVT.syndrome;
      loc_r <= ECC_EVT.location;
      fail_r <= evt_fail;
    end
  end
  // ****************************************
  // diagnostic disables
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
      diag_r <= `MEEL_DIAG_RESET;
    else if (wr_diag)
      diag_r <= WDATA[2:0];
  end
  // ****************************************
  // report requests
  // ****************************************
  // a full log still reports demand errors; only scrub is throttled
  assign ecc_rpt = evt_take && (!ECC_EVT.scrub || log_empty) &&
                   !diag_r[`MEEL_DG_DIS_REPORT] &&
                   !diag_r[`MEEL_DG_DIS_ECC];
  // values 2 and 3 address bus nodes only and are ignored here
  assign test_hit = TEST_REPORT &&
                    ((TEST_SEL == `MEEL_TSEL_CHECKER && !NODE_IS_MASTER) ||
                     (TEST_SEL == `MEEL_TSEL_MASTER && NODE_IS_MASTER));

  always_ff @(posedge CLK)
  begin
    if (RESET)
      test_pend_r <= 1'b0;
    else if (test_hit)
      test_pend_r <= 1'b1;
    else if (!ecc_rpt)
      test_pend_r <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      req_r <= 1'b0;
      kind_r <= meel_pkg::MEEL_RPT_TEST;
    end
    else if (ecc_rpt)
    begin
      // ecc reports go first; a waiting test report follows later
      req_r <= 1'b1;
      kind_r <= evt_corr ? meel_pkg::MEEL_RPT_CORR
                         : meel_pkg::MEEL_RPT_UNCORR;
    end
    else if (test_pend_r)
    begin
      req_r <= 1'b1;
      kind_r <= meel_pkg::MEEL_RPT_TEST;
    end
    else
      req_r <= 1'b0;
  end

  assign REPORT_REQ = req_r;
  assign REPORT_KIND = kind_r;
  // ****************************************
  // report log count
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rcnt_r <= 2'h0;
    else if (REPORT_SEEN)
    begin
      // a report beside the broadcast survives it
      if (LOG_RESET_BCAST)
        rcnt_r <= `MEEL_CNT_ONE;
      else if (rcnt_r != `MEEL_CNT_MAX)
        rcnt_r <= rcnt_r + 2'h1;
    end
    else if (LOG_RESET_BCAST)
      rcnt_r <= 2'h0;
  end
  // ****************************************
  // read port
  // ****************************************
  always_comb
  begin
    up_word = 16'h0000;
    up_word[`MEEL_UP_SCRUB] = scrub_r;
    up_word[`MEEL_UP_SYN_HI:`MEEL_UP_SYN_LO] = syn_r;
    up_word[`MEEL_UP_FBE] = fbe_r;
    up_word[`MEEL_UP_OVF] = ovf_r;
    up_word[`MEEL_UP_UNC] = unc_r;
    up_word[`MEEL_UP_COR] = cor_r;
    up_word[`MEEL_UP_LOC_HI:0] = loc_r[19:`MEEL_LOC_SPLIT];
  end

  always_comb
  begin
    st_word = 16'h0000;
    st_word[`MEEL_ST_CNT_HI:`MEEL_ST_CNT_LO] = rcnt_r;
    st_word[`MEEL_ST_PEND] = test_pend_r;
    st_word[`MEEL_ST_KIND_HI:`MEEL_ST_KIND_LO] = fail_r.kind;
    st_word[`MEEL_ST_IDX_HI:0] = fail_r.index;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      rdata_r <= 16'h0000;
    else if (RD)
    begin
      case (ADDR)
        `MEEL_ADDR_UPPER: rdata_r <= up_word;
        `MEEL_ADDR_LOWER: rdata_r <= loc_r[`MEEL_LOC_SPLIT-1:0];
        `MEEL_ADDR_DIAG: rdata_r <= {13'h0000, diag_r};
        `MEEL_ADDR_STATUS: rdata_r <= st_word;
        default: rdata_r <= 16'h0000;
      endcase
    end
    else
      rdata_r <= 16'h0000;
  end

  assign RDATA = rdata_r;
endmodule // meel_top
`default_nettype wire

// File: verif/meel_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "meel_map.svh"
module meel_top_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // events and commands
  input wire meel_pkg::meel_ecc_evt_s ECC_EVT,
  input wire logic FBE_OP,
  input wire logic TEST_REPORT,
  input wire logic [1:0] TEST_SEL,
  input wire logic NODE_IS_MASTER,
  input wire logic LOG_RESET_BCAST,
  // report network
  input wire logic REPORT_SEEN,
  input wire logic REPORT_REQ,
  input wire meel_pkg::meel_rpt_e REPORT_KIND
);
  // **********
  // properties
  // **********
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic sel_ok;
  assign sel_ok = (TEST_SEL == 2'h0 && !NODE_IS_MASTER)
    || (TEST_SEL == 2'h1 && NODE_IS_MASTER);
  // quiet event window, else an ecc report may legally delay the test
  chk_test_fires:
  assert property (TEST_REPORT && sel_ok && !ECC_EVT.valid ##1
    !ECC_EVT.valid |=> REPORT_REQ
    && REPORT_KIND == meel_pkg::MEEL_RPT_TEST)
    else $error("test report not emitted");
  chk_test_ignored:
  assert property (TEST_REPORT && !sel_ok && !ECC_EVT.valid ##1
    !ECC_EVT.valid |=> !REPORT_REQ)
    else $error("unselected test report emitted");
  chk_read_idle:
  assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data outside read slot");
  chk_bad_addr:
  assert property (RD && ADDR[2] |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  chk_log_taken:
  assert property (ECC_EVT.valid && !ECC_EVT.scrub ##1 !WR ##1
    RD && ADDR == `MEEL_ADDR_UPPER |=> RDATA[5] || RDATA[4])
    else $error("log empty after error");
  chk_one_sev:
  assert property (RD && ADDR == `MEEL_ADDR_UPPER |=>
    !(RDATA[5] && RDATA[4]))
    else $error("both severity flags set");
  chk_fbe_seen:
  assert property (FBE_OP ##1 !WR ##1 RD && ADDR == `MEEL_ADDR_UPPER
    |=> RDATA[7])
    else $error("forced-bad flag not set");
  chk_bcast_clear:
  assert property (LOG_RESET_BCAST && !REPORT_SEEN ##1 !REPORT_SEEN ##1
    RD && ADDR == `MEEL_ADDR_STATUS && !REPORT_SEEN
    |=> RDATA[15:14] == 2'h0)
    else $error("report count not cleared");
  cover property (TEST_REPORT && sel_ok ##2 REPORT_REQ);
  cover property (ECC_EVT.valid && ECC_EVT.scrub);
  cover property (LOG_RESET_BCAST);
endmodule // meel_top_chk
`default_nettype wire

// File: verif/meel_net_model.sv
`timescale 1ns/1ps
`default_nettype none
module meel_net_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // report network
  input wire logic report_req,
  input wire logic slow,
  output logic report_seen
);
  // **********
  // echo
  // **********
  // a new report restarts the hop count, so close reports may merge
  logic [2:0] wait_r;
  always_ff @(posedge clk)
  begin
    if (reset)
      wait_r <= 3'h0;
    else if (report_req)
      wait_r <= slow ? 3'h4 : 3'h1;
    else if (wait_r != 3'h0)
      wait_r <= wait_r - 3'h1;
  end
  assign report_seen = (wait_r == 3'h1);
endmodule // meel_net_model
`default_nettype wire

// File: verif/meel_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "meel_map.svh"
module meel_top_tb;
  // **********
  // bench
  // **********
  logic CLK = 0, RESET = 1, WR = 0, RD = 0, FBE_OP = 0, TEST_REPORT = 0;
  logic NODE_IS_MASTER = 0, LOG_RESET_BCAST = 0, REPORT_SEEN, REPORT_REQ;
  logic slow = 0, rd_d = 0;
  logic [2:0] ADDR = 3'h0;
  logic [1:0] TEST_SEL = 2'h0;
  logic [15:0] WDATA = 16'h0000, RDATA;
  logic [19:0] loc, l0;
  meel_pkg::meel_ecc_evt_s ECC_EVT = '0;
  meel_pkg::meel_rpt_e REPORT_KIND;
  meel_pkg::meel_rpt_e rq[$];
  logic [31:0] dq[$];
  int miscompares = 0, compares = 0;
  always #12.5 CLK = ~CLK;
  meel_top dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .ECC_EVT(ECC_EVT), .FBE_OP(FBE_OP),
    .TEST_REPORT(TEST_REPORT), .TEST_SEL(TEST_SEL),
    .NODE_IS_MASTER(NODE_IS_MASTER), .LOG_RESET_BCAST(LOG_RESET_BCAST),
    .REPORT_SEEN(REPORT_SEEN), .REPORT_REQ(REPORT_REQ),
    .REPORT_KIND(REPORT_KIND));
  meel_net_model net (.clk(CLK), .reset(RESET), .report_req(REPORT_REQ),
    .slow(slow), .report_seen(REPORT_SEEN));
  // strobe picked by code: 0 write, 1 forced-bad, 2 test, 3 broadcast
  task automatic pulse(input int w);
    @(posedge CLK);
    case (w)
      0: WR <= 1'b1;
      1: FBE_OP <= 1'b1;
      2: TEST_REPORT <= 1'b1;
      default: LOG_RESET_BCAST <= 1'b1;
    endcase
    @(posedge CLK);
    case (w)
      0: WR <= 1'b0;
      1: FBE_OP <= 1'b0;
      2: TEST_REPORT <= 1'b0;
      default: LOG_RESET_BCAST <= 1'b0;
    endcase
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    pulse(0);
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] m,
    input logic [15:0] v);
    dq.push_back({m, v});
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
  endtask
  task automatic ecc(input logic s, input logic [6:0] syn);
    loc = 20'($urandom);
    @(posedge CLK);
    slow <= 1'($urandom);
    ECC_EVT <= {1'b1, s, syn, loc};
    @(posedge CLK);
    ECC_EVT <= '0;
  endtask
  task automatic test(input logic m, input logic [1:0] s);
    NODE_IS_MASTER <= m;
    TEST_SEL <= s;
    pulse(2);
    repeat (6) @(posedge CLK);
  endtask
  task automatic tally_and_finish;
    if (rq.size() != 0)
    begin
      miscompares++;
      $display("MISMATCH %0t report missing", $time);
    end
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // the oldest note is consumed even on mismatch, to stay aligned
  always @(posedge CLK)
  begin
    rd_d <= RD;
    if (rd_d)
    begin
      compares++;
      if ((RDATA & dq[0][31:16]) !== dq[0][15:0])
      begin
        miscompares++;
        $display("MISMATCH %0t read %h", $time, RDATA);
      end
      void'(dq.pop_front());
    end
    if (REPORT_REQ === 1'b1)
    begin
      compares++;
      if (rq.size() == 0 || REPORT_KIND !== rq[0])
      begin
        miscompares++;
        $display("MISMATCH %0t report %0d", $time, REPORT_KIND);
      end
      if (rq.size() != 0)
        void'(rq.pop_front());
    end
  end
  initial
  begin
    repeat (5000) @(posedge CLK);
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    static logic [6:0] syn [7] =
      '{7'h49, 7'h1F, 7'h01, 7'h6D, 7'h4A, 7'h7F, 7'h03};
    static logic [2:0] knd [7] =
      '{3'h1, 3'h1, 3'h3, 3'h2, 3'h2, 3'h4, 3'h0};
    static logic [4:0] idx [7] =
      '{5'h00, 5'h1F, 5'h00, 5'h00, 5'h0A, 5'h00, 5'h00};
    logic c;
    void'($urandom(69385));
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    rd(`MEEL_ADDR_DIAG, 16'h0007, 16'h0000);
    rd(`MEEL_ADDR_UPPER, 16'hFFFF, 16'h0000);
    rd(3'h5, 16'hFFFF, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      c = (i < 3);
      rq.push_back(c ? meel_pkg::MEEL_RPT_CORR : meel_pkg::MEEL_RPT_UNCORR);
      ecc(1'b0, syn[i]);
      rd(`MEEL_ADDR_UPPER, 16'hFFFF,
        {1'b0, syn[i], 2'b00, !c, c, loc[19:16]});
      rd(`MEEL_ADDR_LOWER, 16'hFFFF, loc[15:0]);
      rd(`MEEL_ADDR_STATUS, (i < 5) ? 16'h071F : 16'h0700,
        {5'h00, knd[i], 3'h0, idx[i]});
      wr(`MEEL_ADDR_UPPER, 16'h00F0);
    end
    wr(`MEEL_ADDR_DIAG, 16'h0002);
    ecc(1'b0, 7'h49);
    l0 = loc;
    ecc(1'b0, 7'h6D);
    pulse(1);
    rd(`MEEL_ADDR_UPPER, 16'hFFFF, {1'b0, 7'h49, 4'hD, l0[19:16]});
    rd(`MEEL_ADDR_LOWER, 16'hFFFF, l0[15:0]);
    wr(`MEEL_ADDR_UPPER, 16'h0040);
    rd(`MEEL_ADDR_UPPER, 16'h00F0, 16'h0090);
    wr(`MEEL_ADDR_UPPER, 16'h0010);
    rd(`MEEL_ADDR_UPPER, 16'h00F0, 16'h0080);
    wr(`MEEL_ADDR_UPPER, 16'h0080);
    wr(`MEEL_ADDR_DIAG, 16'h0000);
    rq.push_back(meel_pkg::MEEL_RPT_CORR);
    ecc(1'b0, 7'h01);
    l0 = loc;
    ecc(1'b1, 7'h49);
    rd(`MEEL_ADDR_UPPER, 16'hFFFF, {1'b0, 7'h01, 4'h5, l0[19:16]});
    wr(`MEEL_ADDR_UPPER, 16'h00F0);
    rq.push_back(meel_pkg::MEEL_RPT_CORR);
    ecc(1'b1, 7'h49);
    rd(`MEEL_ADDR_UPPER, 16'h80F0, 16'h8010);
    wr(`MEEL_ADDR_UPPER, 16'h00F0);
    wr(`MEEL_ADDR_DIAG, 16'h0004);
    ecc(1'b1, 7'h49);
    rd(`MEEL_ADDR_UPPER, 16'h00F0, 16'h0000);
    wr(`MEEL_ADDR_DIAG, 16'h0001);
    ecc(1'b0, 7'h49);
    rd(`MEEL_ADDR_UPPER, 16'h00F0, 16'h0010);
    wr(`MEEL_ADDR_UPPER, 16'h00F0);
    for (int k = 0; k < 8; k++)
    begin
      if ((k[2:1] == 0 && !k[0]) || (k[2:1] == 1 && k[0]))
        rq.push_back(meel_pkg::MEEL_RPT_TEST);
      test(k[0], k[2:1]);
    end
    rd(`MEEL_ADDR_STATUS, 16'hC000, 16'hC000);
    pulse(3);
    rd(`MEEL_ADDR_STATUS, 16'hC000, 16'h0000);
    rq.push_back(meel_pkg::MEEL_RPT_TEST);
    test(1'b0, 2'h0);
    rd(`MEEL_ADDR_STATUS, 16'hC000, 16'h4000);
    repeat (6) @(posedge CLK);
    tally_and_finish();
  end
endmodule // meel_top_tb
bind meel_top meel_top_chk chk (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
  .WR(WR), .RD(RD), .RDATA(RDATA), .ECC_EVT(ECC_EVT), .FBE_OP(FBE_OP),
  .TEST_REPORT(TEST_REPORT), .TEST_SEL(TEST_SEL),
  .NODE_IS_MASTER(NODE_IS_MASTER), .LOG_RESET_BCAST(LOG_RESET_BCAST),
  .REPORT_SEEN(REPORT_SEEN), .REPORT_REQ(REPORT_REQ),
  .REPORT_KIND(REPORT_KIND));
`default_nettype wire
